// *** logic/ubc_defs.svh ***
// Constants of the bulk-only command decoder: offsets, codes, sizes.
// Assumes inclusion by bare name from the decoder module.
`ifndef UBC_DEFS_SVH
`define UBC_DEFS_SVH
// Command wrapper size in bytes, status wrapper last byte index
`define UBC_CMD_LEN      5'd31
`define UBC_CSW_LAST     4'd12
// Signatures, as 32-bit values sent low byte first
`define UBC_CBW_SIG      32'h43425355
`define UBC_CSW_SIG      32'h53425355
// Byte offsets inside the command wrapper
`define UBC_OFS_TAG      4
`define UBC_OFS_LEN      8
`define UBC_OFS_FLAGS    12
`define UBC_OFS_CBLEN    14
`define UBC_OFS_CB       15
`define UBC_OFS_VTAG     29
`define UBC_DIR_BIT      7
`define UBC_CBLEN_MAX    8'h10
// Command block indices (offset minus 15)
`define UBC_CB_ADDR      4'd2
`define UBC_CB_TGT       4'd6
`define UBC_CB_SECT      4'd7
// Status codes
`define UBC_ST_PASS      8'h00
`define UBC_ST_FAIL      8'h01
`define UBC_ST_PHASE     8'h02
// Operation codes
`define UBC_OP_VERSION   16'hf010
`define UBC_OP_FL_READ   16'hfd28
`define UBC_OP_FL_WRITE  16'hfd2a
`define UBC_OP_FL_SECT   16'hfd20
`define UBC_OP_FL_CHIP   16'hfdff
`define UBC_NIB_HC_WR    4'he
`define UBC_NIB_HC_RD    4'hd
`define UBC_TGT_NOR      8'h06
// Sizes
`define UBC_SECT_SHIFT   9
`define UBC_SECT_ERASE   32'h00010000
`define UBC_CHIP_ERASE   32'h00400000
`define UBC_VER_LAST     4'd10
`endif

// *** logic/ubc_pkg.sv ***
// Types shared by the bulk-only command decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package ubc_pkg;
    // Controller states, one-hot
    typedef enum logic [5:0] {
        UBC_IDLE   = 6'b000001,
        UBC_CHECK  = 6'b000010,
        UBC_EXEC   = 6'b000100,
        UBC_DATA   = 6'b001000,
        UBC_WAIT   = 6'b010000,
        UBC_STATUS = 6'b100000
    } ubc_state_e;
    // Operation handed to the flash engine
    typedef enum logic [1:0] {
        UBC_FL_READ  = 2'h0,
        UBC_FL_WRITE = 2'h1,
        UBC_FL_SECT  = 2'h2,
        UBC_FL_CHIP  = 2'h3
    } ubc_fop_e;
endpackage

// *** logic/ubc_decoder.sv ***
// Bulk-only command decoder: takes command wrappers from bulk-out,
// runs vendor commands, moves data, answers with a status wrapper.
// Assumes packet engine, flash engine and host-controller path on
// the same clock; streams handshake with valid/ready, the flash engine with start/done.
//
// How it works
// - Wrapper is one 31-byte short packet
// - Accept only signature 43425355h
// - Keep the host tag per command
// - Zero length: no data, ignore direction
// - Flag bit 7 gives data direction
// - Command length only 1 to 16
// - Ignore command bytes past length
// - Status is one 13-byte short packet
// - Status signature is 53425355h
// - Status tag echoes command tag
// - Residue is expected minus moved bytes
// - Status codes 00h, 01h, 02h only
// - FD 20 erases a 64K sector
// - FD FF erases whole 4M flash
// - Ex xx forwards data to controller
// - Dx xx fetches data from controller
// - F0 10 returns 11 version bytes
// - Flash address and length high first
// - Flash target byte must be 06h
// - Flash length counts 512-byte sectors
// - FD 2A programs data-out bytes
// - Bytes 29-30 carry vendor tag
`timescale 1ns/10ps
`include "ubc_defs.svh"

module ubc_decoder #(
    parameter logic [87:0] VERSION_INFO = 88'h0 // Arbitrary value
) (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    // Bulk-out byte stream
    input  wire logic [7:0]        bo_data_in,
    input  wire logic              bo_valid_in,
    input  wire logic              bo_last_in,
    output logic                   bo_ready_out,
    // Bulk-in byte stream
    output logic [7:0]             bi_data_out,
    output logic                   bi_valid_out,
    output logic                   bi_last_out,
    input  wire logic              bi_ready_in,
    // Flash engine
    output logic                   fl_start_out,
    output ubc_pkg::ubc_fop_e      fl_op_out,
    output logic [31:0]            fl_addr_out,
    output logic [31:0]            fl_bytes_out,
    input  wire logic              fl_done_in,
    input  wire logic              fl_ok_in,
    // Host-controller path
    output logic                   hc_start_out,
    output logic                   hc_write_out,
    output logic [15:0]            hc_opcode_out,
    // Payload toward flash or controller
    output logic [7:0]             po_data_out,
    output logic                   po_valid_out,
    input  wire logic              po_ready_in,
    // Payload from flash or controller
    input  wire logic [7:0]        pi_data_in,
    input  wire logic              pi_valid_in,
    input  wire logic              pi_last_in,
    output logic                   pi_ready_out,
    // Status
    output logic [15:0]            vendor_tag_out,
    output logic                   busy_out,
    output logic                   drop_out
);
    import ubc_pkg::*;

    // ==========================================================
    // Storage and fields
    // ==========================================================
    ubc_state_e  state;            // Controller state
    ubc_state_e  next_state;       // Its next value
    logic [7:0]  cbw [0:30];       // Received wrapper bytes
    logic [4:0]  rx_cnt;           // Bytes received so far
    logic        rx_over;          // Packet ran past 31 bytes
    logic [31:0] cnt;              // Data bytes moved
    logic [3:0]  csw_idx;          // Status byte index
    logic [7:0]  st_code;          // Status code held
    logic        mv_in;            // Data phase is device-to-host
    logic        src_ver;          // Data-in from version table
    logic        bi_free;          // Bulk-in register can load
    logic        po_free;          // Payload-out register can load
    logic        take_in;          // Data-in byte taken
    logic        take_out;         // Data-out byte taken
    logic        take_last;        // Taken byte ends data phase
    logic [7:0]  in_byte;          // Data-in byte selected
    logic [7:0]  csw_byte;         // Status byte selected
    logic [103:0] csw_vec;         // Whole status wrapper, byte 0 low
    logic [31:0] sig;              // Wrapper signature
    logic [31:0] tag;              // Host tag
    logic [31:0] xlen;             // Expected transfer length
    logic [31:0] residue;          // Expected minus moved
    logic [15:0] opcode;           // Vendor operation code
    logic        cblen_ok;         // Command length legal
    logic        d_in;             // Command wants data-in
    logic        d_out;            // Command wants data-out
    logic        d_ver;            // Version query
    logic        d_fl;             // Flash command
    logic        d_hc;             // Controller pass-through
    logic        d_erase;          // Flash erase
    ubc_fop_e    d_fop;            // Flash operation
    logic [7:0]  d_st;             // Decoded status

    // Command block byte, zero past the valid length
    function automatic logic [7:0] cb_byte(input logic [3:0] idx);
        cb_byte = ({1'b0, idx} < cbw[`UBC_OFS_CBLEN][4:0]) ? cbw[`UBC_OFS_CB + idx] : 8'h00;
    endfunction

    // Wrapper fields, low byte first; opcode high byte first
    assign sig     = {cbw[3], cbw[2], cbw[1], cbw[0]};
    assign tag     = {cbw[`UBC_OFS_TAG+3], cbw[`UBC_OFS_TAG+2],
                      cbw[`UBC_OFS_TAG+1], cbw[`UBC_OFS_TAG]};
    assign xlen    = {cbw[`UBC_OFS_LEN+3], cbw[`UBC_OFS_LEN+2],
                      cbw[`UBC_OFS_LEN+1], cbw[`UBC_OFS_LEN]};
    assign opcode  = {cb_byte(4'd0), cb_byte(4'd1)};
    assign cblen_ok = (cbw[`UBC_OFS_CBLEN] != 8'h00) &&
                      (cbw[`UBC_OFS_CBLEN] <= `UBC_CBLEN_MAX);
    // never above expected, since cnt stops at xlen
    assign residue = xlen - cnt;
    assign busy_out = (state != UBC_IDLE);

    // ==========================================================
    // Command decode
    // ==========================================================
    // Classify the operation; bits 6..0 of flags and the unit
    // number are the host's to keep zero and are not checked.
    always_comb begin
        d_in    = 1'b0;
        d_out   = 1'b0;
        d_ver   = 1'b0;
        d_fl    = 1'b0;
        d_hc    = 1'b0;
        d_erase = 1'b0;
        d_fop   = UBC_FL_READ;
        d_st    = `UBC_ST_PASS;
        if (opcode == `UBC_OP_VERSION) begin
            d_in  = 1'b1;
            d_ver = 1'b1;
        end else if (opcode == `UBC_OP_FL_READ) begin
            d_fl = 1'b1;
            d_in = 1'b1;
        end else if (opcode == `UBC_OP_FL_WRITE) begin
            d_fl  = 1'b1;
            d_out = 1'b1;
            d_fop = UBC_FL_WRITE;
        end else if (opcode == `UBC_OP_FL_SECT) begin
            d_fl    = 1'b1;
            d_erase = 1'b1;
            d_fop   = UBC_FL_SECT;
        end else if (opcode == `UBC_OP_FL_CHIP) begin
            d_fl    = 1'b1;
            d_erase = 1'b1;
            d_fop   = UBC_FL_CHIP;
        end else if (opcode[15:12] == `UBC_NIB_HC_WR) begin
            d_hc  = 1'b1;
            d_out = 1'b1;
        end else if (opcode[15:12] == `UBC_NIB_HC_RD) begin
            d_hc = 1'b1;
            d_in = 1'b1;
        end else begin
            d_st = `UBC_ST_FAIL;
        end
        if (d_fl && (cb_byte(`UBC_CB_TGT) != `UBC_TGT_NOR)) begin
            d_st = `UBC_ST_FAIL;
        end
        // direction must match; ignored when zero
        if ((d_st == `UBC_ST_PASS) && (xlen != 32'h0) &&
            ((d_in && !cbw[`UBC_OFS_FLAGS][`UBC_DIR_BIT]) ||
             (d_out && cbw[`UBC_OFS_FLAGS][`UBC_DIR_BIT]))) begin
            d_st = `UBC_ST_PHASE;
        end
    end

    // ==========================================================
    // Handshakes and next state
    // ==========================================================
    assign bi_free  = !bi_valid_out || bi_ready_in;
    assign po_free  = !po_valid_out || po_ready_in;
    assign in_byte  = src_ver ? VERSION_INFO[8*(`UBC_VER_LAST - cnt[3:0]) +: 8]
                              : pi_data_in;
    assign pi_ready_out = (state == UBC_DATA) && mv_in && !src_ver && bi_free;
    assign take_in  = (state == UBC_DATA) && mv_in && bi_free &&
                      (src_ver || pi_valid_in);
    assign take_out = (state == UBC_DATA) && !mv_in && po_free && bo_valid_in;
    // Stop at expected length or at the source's end
    assign take_last = (cnt + 32'h1 == xlen) ||
                       (take_out && bo_last_in) ||
                       (take_in && !src_ver && pi_last_in) ||
                       (take_in && src_ver && (cnt[3:0] == `UBC_VER_LAST));
    // Bulk-out is held off outside collection and data-out
    assign bo_ready_out = (state == UBC_IDLE) ||
                          ((state == UBC_DATA) && !mv_in && po_free);

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            UBC_IDLE: begin
                // exactly 31 bytes in one packet
                if (bo_valid_in && bo_last_in && !rx_over &&
                    (rx_cnt == `UBC_CMD_LEN - 5'd1)) begin
                    next_state = UBC_CHECK;
                end
            end
            UBC_CHECK: begin
                // signature and drop on bad wrapper
                next_state = ((sig == `UBC_CBW_SIG) && cblen_ok) ? UBC_EXEC : UBC_IDLE;
            end
            UBC_EXEC: begin
                if (d_st != `UBC_ST_PASS) begin
                    next_state = UBC_STATUS;
                end else if (d_erase) begin
                    next_state = UBC_WAIT;
                end else if ((d_in || d_out) && (xlen != 32'h0)) begin
                    next_state = UBC_DATA;
                end else begin
                    next_state = UBC_STATUS;
                end
            end
            UBC_DATA:   next_state = ((take_in || take_out) && take_last) ? UBC_STATUS : state;
            UBC_WAIT:   next_state = fl_done_in ? UBC_STATUS : state;
            UBC_STATUS: next_state = (bi_free && (csw_idx == `UBC_CSW_LAST)) ? UBC_IDLE : state;
            default: next_state = UBC_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state <= UBC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Wrapper collection
    // ==========================================================
    // Bytes stored by position; a packet of any other size is
    // counted but never executed.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rx_cnt  <= 5'd0;
            rx_over <= 1'b0;
            for (int i = 0; i < 31; i++) begin
                cbw[i] <= 8'h00;
            end
        end else if ((state == UBC_IDLE) && bo_valid_in) begin
            if (!rx_over && (rx_cnt < `UBC_CMD_LEN)) begin
                cbw[rx_cnt] <= bo_data_in;
            end
            if (bo_last_in) begin
                rx_cnt  <= 5'd0;
                rx_over <= 1'b0;
            end else if (rx_cnt == `UBC_CMD_LEN - 5'd1) begin
                rx_over <= 1'b1;
            end else if (!rx_over) begin
                rx_cnt <= rx_cnt + 5'd1;
            end
        end
    end

    // Drop pulse on a discarded wrapper
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            drop_out <= 1'b0;
        end else begin
            drop_out <= ((state == UBC_IDLE) && bo_valid_in && bo_last_in &&
                         (rx_over || (rx_cnt != `UBC_CMD_LEN - 5'd1))) ||
                        ((state == UBC_CHECK) && (next_state == UBC_IDLE));
        end
    end

    // ==========================================================
    // Execution
    // ==========================================================
    // Latch the decode outcome and start the engines
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_code        <= `UBC_ST_PASS;
            mv_in          <= 1'b0;
            src_ver        <= 1'b0;
            fl_start_out   <= 1'b0;
            fl_op_out      <= UBC_FL_READ;
            fl_addr_out    <= 32'h0;
            fl_bytes_out   <= 32'h0;
            hc_start_out   <= 1'b0;
            hc_write_out   <= 1'b0;
            hc_opcode_out  <= 16'h0;
            vendor_tag_out <= 16'h0;
        end else begin
            fl_start_out <= 1'b0;
            hc_start_out <= 1'b0;
            if (state == UBC_EXEC) begin
                // only the three codes are produced
                st_code <= d_st;
                mv_in   <= d_in;
                src_ver <= d_ver;
                vendor_tag_out <= {cbw[`UBC_OFS_VTAG], cbw[`UBC_OFS_VTAG+1]};
                if (d_st == `UBC_ST_PASS) begin
                    fl_start_out <= d_fl;
                    hc_start_out <= d_hc;
                end
                hc_write_out  <= d_out;
                hc_opcode_out <= opcode;
                fl_op_out     <= d_fop;
                fl_addr_out <= {cb_byte(`UBC_CB_ADDR), cb_byte(`UBC_CB_ADDR + 4'd1),
                                cb_byte(`UBC_CB_ADDR + 4'd2),
                                cb_byte(`UBC_CB_ADDR + 4'd3)};
                if (d_fop == UBC_FL_SECT) begin
                    fl_bytes_out <= `UBC_SECT_ERASE;
                end else if (d_fop == UBC_FL_CHIP) begin
                    fl_bytes_out <= `UBC_CHIP_ERASE;
                end else begin
                    fl_bytes_out <= {7'h0, cb_byte(`UBC_CB_SECT),
                                     cb_byte(`UBC_CB_SECT + 4'd1),
                                     9'h0} >> (9 - `UBC_SECT_SHIFT);
                end
            end else if ((state == UBC_WAIT) && fl_done_in && !fl_ok_in) begin
                st_code <= `UBC_ST_FAIL;
            end
        end
    end

    // Data byte counter
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cnt <= 32'h0;
        end else if (state == UBC_EXEC) begin
            cnt <= 32'h0;
        end else if (take_in || take_out) begin
            cnt <= cnt + 32'h1;
        end
    end

    // Payload-out register toward the engine
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            po_data_out  <= 8'h00;
            po_valid_out <= 1'b0;
        end else if (take_out) begin
            po_data_out  <= bo_data_in;
            po_valid_out <= 1'b1;
        end else if (po_ready_in) begin
            po_valid_out <= 1'b0;
        end
    end

    // ==========================================================
    // Bulk-in: data and status wrapper
    // ==========================================================
    // signature, tag, residue, code
    assign csw_vec  = {st_code, residue, tag, `UBC_CSW_SIG};
    // Index wraps to 0 after 12, so the select never leaves the vector
    assign csw_byte = csw_vec[8*csw_idx +: 8];

    // Output register; status starts after the data packet ends
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            bi_data_out  <= 8'h00;
            bi_valid_out <= 1'b0;
            bi_last_out  <= 1'b0;
            csw_idx      <= 4'd0;
        end else if (take_in) begin
            bi_data_out  <= in_byte;
            bi_valid_out <= 1'b1;
            bi_last_out  <= take_last;
        end else if ((state == UBC_STATUS) && bi_free) begin
            // 13 bytes, last marks the short packet
            bi_data_out  <= csw_byte;
            bi_valid_out <= 1'b1;
            bi_last_out  <= (csw_idx == `UBC_CSW_LAST);
            csw_idx      <= (csw_idx == `UBC_CSW_LAST) ? 4'd0 : csw_idx + 4'd1;
        end else if (bi_ready_in) begin
            bi_valid_out <= 1'b0;
            bi_last_out  <= 1'b0;
        end
    end
endmodule

// *** verification/ubc_decoder_props.sv ***
// Checker on the decoder's top-level ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`include "ubc_defs.svh"
module ubc_decoder_props (
    // Clock and reset
    input wire logic              sys_clk_in,
    input wire logic              rst_n_in,
    // Streams
    input wire logic              bo_ready_out,
    input wire logic [7:0]        bi_data_out,
    input wire logic              bi_valid_out,
    input wire logic              bi_ready_in,
    // Engines
    input wire logic              fl_start_out,
    input wire ubc_pkg::ubc_fop_e fl_op_out,
    input wire logic [31:0]       fl_bytes_out,
    input wire logic              hc_start_out,
    input wire logic              hc_write_out,
    input wire logic [15:0]       hc_opcode_out,
    // Status
    input wire logic              busy_out,
    input wire logic              drop_out
);
    import ubc_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ====================
    // Stalled byte must wait unchanged for the sink
    sequence s_stall;
        bi_valid_out && !bi_ready_in;
    endsequence
    sequence s_held;
        bi_valid_out && $stable(bi_data_out);
    endsequence
    chk_bi_hold: assert property (s_stall |=> s_held)
        else $error("bulk-in byte dropped while stalled");
    chk_sect_size: assert property (fl_start_out && fl_op_out == UBC_FL_SECT
        |-> fl_bytes_out == `UBC_SECT_ERASE)
        else $error("sector erase size wrong");
    chk_chip_size: assert property (fl_start_out && fl_op_out == UBC_FL_CHIP
        |-> fl_bytes_out == `UBC_CHIP_ERASE)
        else $error("chip erase size wrong");
    chk_hc_dir: assert property (hc_start_out
        |-> hc_write_out == (hc_opcode_out[15:12] == `UBC_NIB_HC_WR))
        else $error("controller direction wrong");
    chk_start_pulse: assert property (fl_start_out |=> !fl_start_out && busy_out)
        else $error("flash start not a pulse");
    chk_one_engine: assert property (hc_start_out |-> !fl_start_out ##1 !hc_start_out)
        else $error("both engines started");
    chk_drop_idle: assert property (drop_out |-> !busy_out && !bi_valid_out)
        else $error("discarded wrapper executed");
    chk_check_block: assert property ($rose(busy_out) |-> !bo_ready_out)
        else $error("bulk-out open during check");
endmodule

// *** verification/ubc_host_model.sv ***
// Host model: sends command wrappers on bulk-out, sinks bulk-in.
// Assumes the decoder's clock; requests change on the falling edge.
`timescale 1ns/10ps
module ubc_host_model (
    // Clock and stall control
    input  wire logic       sys_clk_in,
    input  wire logic       slow_in,
    // Bulk-out toward the decoder
    output logic [7:0]      bo_data_out,
    output logic            bo_valid_out,
    output logic            bo_last_out,
    input  wire logic       bo_ready_in,
    // Bulk-in from the decoder
    input  wire logic [7:0] bi_data_in,
    input  wire logic       bi_valid_in,
    input  wire logic       bi_last_in,
    output logic            bi_ready_out
);
    logic [7:0] rx[$];         // Accepted bulk-in bytes
    logic       tick = 1'b0;   // Stall phase
    int         last_n = 0;    // Byte count at the latest packet end
    initial begin
        bo_data_out = 8'h00;
        bo_valid_out = 1'b0;
        bo_last_out = 1'b0;
        bi_ready_out = 1'b1;
    end
    // Slow sink takes a byte every other cycle only
    always @(negedge sys_clk_in) begin
        tick = ~tick;
        bi_ready_out = ~slow_in | tick;
    end
    always @(posedge sys_clk_in) begin
        if (bi_valid_in && bi_ready_out) begin
            rx.push_back(bi_data_in);
            if (bi_last_in) last_n = rx.size();
        end
    end
    task automatic send(input logic [31:0] sig, input logic [31:0] tag,
                        input logic [31:0] len, input logic dir, input logic [15:0] op);
        logic [7:0] w[31];
        int k;
        w = '{default: 8'h00};
        for (int i = 0; i < 4; i++) begin
            w[i] = sig[8*i +: 8];
            w[4+i] = tag[8*i +: 8];
            w[8+i] = len[8*i +: 8];
            w[17+i] = 8'h12 + 8'(34 * i);
        end
        w[12] = {dir, 7'h00};
        w[14] = 8'h10;
        w[15] = op[15:8];
        w[16] = op[7:0];
        w[21] = 8'h06;
        w[29] = 8'ha5;
        w[30] = 8'h5a;
        for (int i = 0; i < 31; i++) begin
            @(negedge sys_clk_in);
            bo_data_out = w[i];
            bo_valid_out = 1'b1;
            bo_last_out = (i == 30);
            k = 0;
            while (!bo_ready_in && k < 50) begin
                @(negedge sys_clk_in);
                k++;
            end
            @(posedge sys_clk_in);
        end
        // Released bus shows a changed value
        @(negedge sys_clk_in);
        bo_valid_out = 1'b0;
        bo_last_out = 1'b0;
        bo_data_out = ~bo_data_out;
    endtask
endmodule

// *** verification/ubc_decoder_test.sv ***
// Bench for the command decoder: wrappers in, status wrappers judged.
// Assumes the host model and checker are compiled beforehand.
`timescale 1ns/10ps
`include "ubc_defs.svh"
module ubc_decoder_test;
    import ubc_pkg::*;
    // ====================
    // Design signals
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, slow = 1'b0, ok = 1'b1;
    logic [7:0] bo_data, bi_data_out, po_data_out;
    logic bo_valid, bo_last, bo_ready_out, bi_valid_out, bi_last_out, bi_ready;
    logic fl_start_out, fl_done_in = 1'b0, hc_start_out, hc_write_out, po_valid_out;
    logic pi_ready_out, busy_out, drop_out, dropped = 1'b0;
    ubc_fop_e fl_op_out, f_op;
    logic [31:0] fl_addr_out, fl_bytes_out, f_addr;
    logic [15:0] hc_opcode_out, vendor_tag_out;
    int errors = 0, checks = 0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    ubc_decoder #(.VERSION_INFO(88'h0102030405060708090a0b)) ubc_decoder_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bo_data_in(bo_data),
        .bo_valid_in(bo_valid), .bo_last_in(bo_last), .bo_ready_out(bo_ready_out),
        .bi_data_out(bi_data_out), .bi_valid_out(bi_valid_out), .bi_last_out(bi_last_out),
        .bi_ready_in(bi_ready), .fl_start_out(fl_start_out), .fl_op_out(fl_op_out),
        .fl_addr_out(fl_addr_out), .fl_bytes_out(fl_bytes_out), .fl_done_in(fl_done_in),
        .fl_ok_in(ok), .hc_start_out(hc_start_out), .hc_write_out(hc_write_out),
        .hc_opcode_out(hc_opcode_out), .po_data_out(po_data_out), .po_valid_out(po_valid_out),
        .po_ready_in(1'b1), .pi_data_in(8'h00), .pi_valid_in(1'b0), .pi_last_in(1'b0),
        .pi_ready_out(pi_ready_out), .vendor_tag_out(vendor_tag_out), .busy_out(busy_out),
        .drop_out(drop_out));
    ubc_host_model ubc_host_model_inst (.sys_clk_in(sys_clk_in), .slow_in(slow),
        .bo_data_out(bo_data), .bo_valid_out(bo_valid), .bo_last_out(bo_last),
        .bo_ready_in(bo_ready_out), .bi_data_in(bi_data_out), .bi_valid_in(bi_valid_out),
        .bi_last_in(bi_last_out),
        .bi_ready_out(bi_ready));
    // Flash engine stand-in: done half a cycle after each start
    always @(negedge sys_clk_in) fl_done_in <= fl_start_out;
    always @(posedge sys_clk_in) begin
        if (fl_start_out) begin
            f_addr <= fl_addr_out;
            f_op <= fl_op_out;
        end
        if (drop_out) dropped <= 1'b1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] le32(input int b);
        return {ubc_host_model_inst.rx[b+3], ubc_host_model_inst.rx[b+2],
                ubc_host_model_inst.rx[b+1], ubc_host_model_inst.rx[b]};
    endfunction
    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Shared: one wrapper, nd data bytes expected, then the status
    task automatic run(input logic [15:0] op, input logic [31:0] len, input logic dir,
                       input int nd, input logic [7:0] st);
        int k = 0;
        logic [31:0] tg = {16'h7e00, op};
        ubc_host_model_inst.rx.delete();
        ubc_host_model_inst.send(`UBC_CBW_SIG, tg, len, dir, op);
        while (ubc_host_model_inst.rx.size() < nd + 13 && k < 3000) begin
            @(negedge sys_clk_in);
            k++;
        end
        if (k == 3000) begin
            errors++;
            test_done();
        end
        repeat (4) @(negedge sys_clk_in);
        for (int i = 0; i < nd; i++) chk(ubc_host_model_inst.rx[i], 32'(i + 1));
        chk(32'(ubc_host_model_inst.rx.size()), 32'(nd + 13));
        chk(32'(ubc_host_model_inst.last_n), 32'(nd + 13));
        chk(le32(nd), `UBC_CSW_SIG);
        chk(le32(nd + 4), tg);
        chk(le32(nd + 8), len - 32'(nd));
        chk(ubc_host_model_inst.rx[nd + 12], st);
        chk(vendor_tag_out, 16'ha55a);
        $display("test %h done", op);
    endtask
    task automatic t_version;
        slow = 1'b1;
        run(`UBC_OP_VERSION, 32'd11, 1'b1, 11, `UBC_ST_PASS);
        slow = 1'b0;
    endtask
    task automatic t_sector;
        run(`UBC_OP_FL_SECT, 32'd0, 1'b1, 0, `UBC_ST_PASS);
        chk(f_addr, 32'h12345678);
        chk(f_op, UBC_FL_SECT);
    endtask
    task automatic t_chip_fail;
        ok = 1'b0;
        run(`UBC_OP_FL_CHIP, 32'd0, 1'b0, 0, `UBC_ST_FAIL);
        chk(f_op, UBC_FL_CHIP);
        ok = 1'b1;
    endtask
    task automatic t_bad_sig;
        ubc_host_model_inst.rx.delete();
        ubc_host_model_inst.send(32'h43425354, 32'h1, 32'h0, 1'b0, `UBC_OP_VERSION);
        repeat (6) @(negedge sys_clk_in);
        chk(dropped, 1'b1);
        chk(32'(ubc_host_model_inst.rx.size()), 32'd0);
        $display("test bad signature done");
    endtask
    initial begin
        repeat (10) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        t_version();
        run(`UBC_OP_VERSION, 32'd5, 1'b0, 0, `UBC_ST_PHASE);
        run(16'h1234, 32'd0, 1'b1, 0, `UBC_ST_FAIL);
        t_sector();
        t_chip_fail();
        run(16'he001, 32'd0, 1'b0, 0, `UBC_ST_PASS);
        run(16'hd002, 32'd0, 1'b1, 0, `UBC_ST_PASS);
        t_bad_sig();
        test_done();
    end
endmodule
bind ubc_decoder ubc_decoder_props ubc_decoder_props_inst (.sys_clk_in, .rst_n_in,
    .bo_ready_out, .bi_data_out, .bi_valid_out, .bi_ready_in, .fl_start_out, .fl_op_out,
    .fl_bytes_out, .hc_start_out, .hc_write_out, .hc_opcode_out, .busy_out, .drop_out);
